/* rtl/hce_defines.vh */
`ifndef HCE_DEFINES_VH
`define HCE_DEFINES_VH

// Timing
`define HCE_CLK_KHZ        10000
`define HCE_DEBOUNCE_MS    10
`define HCE_TE_US          400

// Transmission framing: header and guard in basic elements, preamble and frame in symbols, code in bits
`define HCE_PREAMBLE_SYMS  12
`define HCE_HDR_TE         6'h0a
`define HCE_GUARD_TE       6'h27
`define HCE_CODE_BITS      66
`define HCE_FRAME_SYMS     80

// Symbol codes
`define HCE_SYM_PRE        3'h0
`define HCE_SYM_HDR        3'h1
`define HCE_SYM_ZERO       3'h2
`define HCE_SYM_ONE        3'h3
`define HCE_SYM_GUARD      3'h4

// Code word fields
`define HCE_CW_HOP_LSB     0
`define HCE_CW_SER_LSB     32
`define HCE_CW_FUNC_LSB    60
`define HCE_CW_LOWSUP_BIT  64
`define HCE_CW_REPEAT_BIT  65

// Plaintext fields
`define HCE_PT_SYNC_LSB    0
`define HCE_PT_DISC_LSB    16
`define HCE_PT_OVF_LSB     26
`define HCE_PT_FUNC_LSB    28

// Reset values
`define HCE_SYNC_RST       16'h0000
`define HCE_OVF_RST        2'h0

`endif

/* rtl/hce_fifo.v */
`timescale 1ns/10ps
module hce_fifo #(
  parameter WIDTH = 3,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             clk_sys,
  input  wire             arst_n,
  input  wire             flush,
  // Fill side
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  // Drain side
  output reg              outValid,
  input  wire             outReady,
  output reg  [WIDTH-1:0] outData,
  output wire             empty
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr;
  reg [AW-1:0]    rdPtr;
  reg [AW:0]      count;
  wire            doWrite;
  wire            doRead;

  assign inReady = (count < DEPTH);
  assign doWrite = inValid && inReady && !flush;
  // Head word moves into the output register when it is free
  assign doRead  = (count != 0) && (!outValid || outReady) && !flush;
  assign empty   = (count == 0) && !outValid;

  always @(posedge clk_sys) begin
    if (doWrite) begin
      mem[wrPtr] <= inData;
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr    <= {AW{1'b0}};
      rdPtr    <= {AW{1'b0}};
      count    <= {(AW+1){1'b0}};
      outValid <= 1'b0;
      outData  <= {WIDTH{1'b0}};
    end else if (flush) begin
      wrPtr    <= {AW{1'b0}};
      rdPtr    <= {AW{1'b0}};
      count    <= {(AW+1){1'b0}};
      outValid <= 1'b0;
    end else begin
      if (doWrite) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (doRead) begin
        rdPtr    <= rdPtr + 1'b1;
        outData  <= mem[rdPtr];
        outValid <= 1'b1;
      end else if (outReady) begin
        outValid <= 1'b0;
      end
      if (doWrite && !doRead) begin
        count <= count + 1'b1;
      end else if (doRead && !doWrite) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

/* rtl/hce_core.v */
`timescale 1ns/10ps
`include "hce_defines.vh"
module hce_core #(
  parameter DEBOUNCE_CYCLES = `HCE_DEBOUNCE_MS * `HCE_CLK_KHZ,
  parameter ROUNDS          = 512,
  parameter NLF_TABLE       = 32'h6b2e94d1,
  parameter FIFO_DEPTH      = 16
) (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        arst_n,
  // Button pins
  input  wire        buttonInZero,
  input  wire        buttonInOne,
  input  wire        buttonInTwoProgClock,
  // Supply monitor and mode pins
  input  wire        lowSupplyFlag,
  input  wire        progMode,
  // Stored configuration
  input  wire [63:0] cipherKey,
  input  wire [31:0] serialNumber,
  input  wire [47:0] seedValue,
  input  wire        seedEnable,
  input  wire [9:0]  discBits,
  // Pulse pin
  input  wire        pwmIn,
  output reg         pwmOut,
  output reg         pwmOe,
  // Programming data path
  input  wire        progTxData,
  input  wire        progTxEn,
  output reg         progClkRise,
  output reg         progDataIn,
  // Status
  output wire        awake,
  output reg  [15:0] syncValue,
  output reg         syncWrite
);
  localparam ST_SLEEP    = 3'h0;
  localparam ST_DEBOUNCE = 3'h1;
  localparam ST_CIPHER   = 3'h2;
  localparam ST_LOAD     = 3'h3;
  localparam ST_DRAIN    = 3'h4;

  localparam [31:0] TE_WIDE  = `HCE_TE_US * `HCE_CLK_KHZ / 1000 - 1;
  localparam [31:0] DEB_WIDE = DEBOUNCE_CYCLES - 1;
  localparam [31:0] RND_WIDE = ROUNDS - 1;
  localparam [31:0] PRE_WIDE = `HCE_PREAMBLE_SYMS;
  localparam [31:0] DAT_WIDE = `HCE_PREAMBLE_SYMS + 1 + `HCE_CODE_BITS;
  localparam [31:0] FRM_WIDE = `HCE_FRAME_SYMS - 1;
  // Slices fix the counter widths; larger parameters need wider counters
  localparam [11:0] TE_LAST  = TE_WIDE[11:0];
  localparam [19:0] DEB_LAST = DEB_WIDE[19:0];
  localparam [9:0]  RND_LAST = RND_WIDE[9:0];
  localparam [6:0]  PRE_END  = PRE_WIDE[6:0];
  localparam [6:0]  DAT_END  = DAT_WIDE[6:0];
  localparam [6:0]  FRM_LAST = FRM_WIDE[6:0];

  function [5:0] symHigh;
    input [2:0] sym;
    begin
      case (sym)
        `HCE_SYM_PRE:  symHigh = 6'h01;
        `HCE_SYM_ZERO: symHigh = 6'h02;
        `HCE_SYM_ONE:  symHigh = 6'h01;
        default:       symHigh = 6'h00;
      endcase
    end
  endfunction

  function [5:0] symLen;
    input [2:0] sym;
    begin
      case (sym)
        `HCE_SYM_PRE:   symLen = 6'h02;
        `HCE_SYM_HDR:   symLen = `HCE_HDR_TE;
        `HCE_SYM_GUARD: symLen = `HCE_GUARD_TE;
        default:        symLen = 6'h03;
      endcase
    end
  endfunction

  // Pin synchronisers
  reg [5:0] pinMeta;
  reg [5:0] pinSync;
  reg       progClkLast;
  wire [2:0] buttons  = pinSync[2:0];
  wire       lowSync  = pinSync[3];
  wire       progSync = pinSync[4];
  wire       pwmSync  = pinSync[5];

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pinMeta <= 6'h00;
      pinSync <= 6'h00;
    end else begin
      pinMeta <= {pwmIn, progMode, lowSupplyFlag,
                  buttonInTwoProgClock, buttonInOne, buttonInZero};
      pinSync <= pinMeta;
    end
  end

  // Programming clock and data capture
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      progClkLast <= 1'b0;
      progClkRise <= 1'b0;
      progDataIn  <= 1'b0;
    end else begin
      progClkLast <= buttons[2];
      progClkRise <= progSync && buttons[2] && !progClkLast;
      if (progSync && buttons[2] && !progClkLast) begin
        progDataIn <= pwmSync;
      end
    end
  end

  // Control state
  reg [2:0]  state;
  reg [19:0] debCnt;
  reg [2:0]  btnLatch;
  reg        lowLatch;
  reg [1:0]  ovfCnt;
  reg [9:0]  roundCnt;
  reg [31:0] cipherState;
  reg [63:0] keyRot;
  reg [65:0] codeWord;
  reg        repeatFlag;
  reg [6:0]  symIdx;
  reg        symActive;

  wire       anyButton = |buttons;
  // Held buttons lose nothing; only a new one aborts
  wire       newPress  = |(buttons & ~btnLatch);
  wire       abortWord = !progSync && newPress &&
                         (state == ST_CIPHER || state == ST_LOAD || state == ST_DRAIN);
  wire [3:0] funcCode  = {1'b0, btnLatch};
  wire       seedMode  = (btnLatch == 3'h7) && seedEnable;

  // Fresh buttons and the count before it moves
  wire [31:0] plainText = {1'b0, buttons, ovfCnt, discBits, syncValue};
  wire [4:0]  nlfIdx    = {cipherState[31], cipherState[26], cipherState[20],
                           cipherState[9], cipherState[1]};
  wire        nlfBit    = NLF_TABLE[nlfIdx];
  wire        feedBit   = cipherState[0] ^ cipherState[16] ^ nlfBit ^ keyRot[0];

  assign awake = (state != ST_SLEEP);

  // Symbol producer
  wire       fifoInReady;
  wire       fifoOutValid;
  wire [2:0] fifoOutData;
  wire       fifoEmpty;
  wire       fifoInValid = (state == ST_LOAD);
  reg  [2:0] symNow;
  wire [6:0] bitIdx = symIdx - PRE_END - 7'h01;

  always @* begin
    symNow = `HCE_SYM_GUARD;
    if (symIdx < PRE_END) begin
      symNow = `HCE_SYM_PRE;
    end else if (symIdx == PRE_END) begin
      symNow = `HCE_SYM_HDR;
    end else if (symIdx < DAT_END) begin
      // Least significant bit first puts the hopping code ahead of the fixed part
      symNow = codeWord[bitIdx] ? `HCE_SYM_ONE : `HCE_SYM_ZERO;
    end
  end

  // Main sequencer
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state       <= ST_SLEEP;
      debCnt      <= 20'h00000;
      btnLatch    <= 3'h0;
      lowLatch    <= 1'b0;
      syncValue   <= `HCE_SYNC_RST;
      ovfCnt      <= `HCE_OVF_RST;
      syncWrite   <= 1'b0;
      roundCnt    <= 10'h000;
      cipherState <= 32'h00000000;
      keyRot      <= 64'h0000000000000000;
      codeWord    <= 66'h0;
      repeatFlag  <= 1'b0;
      symIdx      <= 7'h00;
    end else begin
      syncWrite <= 1'b0;
      if (abortWord) begin
        state <= ST_SLEEP;
      end else begin
        case (state)
          ST_SLEEP: begin
            debCnt <= 20'h00000;
            if (anyButton && !progSync) begin
              state <= ST_DEBOUNCE;
            end
          end
          ST_DEBOUNCE: begin
            if (!anyButton) begin
              state <= ST_SLEEP;
            end else if (debCnt == DEB_LAST) begin
              btnLatch  <= buttons;
              lowLatch  <= lowSync;
              // Full 16-bit span before any count repeats
              syncValue <= syncValue + 16'h0001;
              if (syncValue == 16'hffff) begin
                ovfCnt <= ovfCnt + 2'h1;
              end
              syncWrite <= 1'b1;
              state     <= ST_CIPHER;
              roundCnt  <= 10'h000;
              cipherState <= plainText;
              keyRot      <= cipherKey;
            end else begin
              debCnt <= debCnt + 20'h00001;
            end
          end
          ST_CIPHER: begin
            cipherState <= {feedBit, cipherState[31:1]};
            keyRot      <= {keyRot[0], keyRot[63:1]};
            roundCnt    <= roundCnt + 10'h001;
            if (roundCnt == RND_LAST) begin
              state      <= ST_LOAD;
              symIdx     <= 7'h00;
              repeatFlag <= 1'b0;
              if (seedMode) begin
                codeWord <= {1'b0, lowLatch, funcCode, 12'h000, seedValue};
              end else begin
                // Hopping code, low serial bits, then info bits
                codeWord <= {1'b0, lowLatch, funcCode, serialNumber[27:0],
                             feedBit, cipherState[31:1]};
              end
            end
          end
          ST_LOAD: begin
            if (fifoInReady) begin
              if (symIdx == FRM_LAST) begin
                state <= ST_DRAIN;
              end else begin
                symIdx <= symIdx + 7'h01;
              end
            end
          end
          ST_DRAIN: begin
            if (fifoEmpty && !symActive) begin
              symIdx <= 7'h00;
              if (anyButton) begin
                // Word again with the repeat bit set while any button is still held
                codeWord[`HCE_CW_REPEAT_BIT] <= 1'b1;
                repeatFlag <= 1'b1;
                state      <= ST_LOAD;
              end else begin
                state <= ST_SLEEP;
              end
            end
          end
          default: begin
            state <= ST_SLEEP;
          end
        endcase
      end
    end
  end

  // Pulse generator
  reg [2:0]  curSym;
  reg [5:0]  teElapsed;
  reg [11:0] teDiv;
  wire       teTick      = symActive && (teDiv == TE_LAST);
  wire       symDone     = teTick && (teElapsed == symLen(curSym) - 6'h01);
  wire       fifoOutReady = !symActive || symDone;
  wire       pwmLine     = symActive && (teElapsed < symHigh(curSym));

  hce_fifo #(
    .WIDTH (3),
    .DEPTH (FIFO_DEPTH),
    .AW    (4)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .flush    (abortWord),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (symNow),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOutData),
    .empty    (fifoEmpty)
  );

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      symActive <= 1'b0;
      curSym    <= `HCE_SYM_GUARD;
      teElapsed <= 6'h00;
      teDiv     <= 12'h000;
    end else if (abortWord) begin
      symActive <= 1'b0;
      teElapsed <= 6'h00;
      teDiv     <= 12'h000;
    end else if (fifoOutReady && fifoOutValid) begin
      symActive <= 1'b1;
      curSym    <= fifoOutData;
      teElapsed <= 6'h00;
      teDiv     <= 12'h000;
    end else if (symDone) begin
      symActive <= 1'b0;
    end else if (symActive) begin
      if (teTick) begin
        teDiv     <= 12'h000;
        teElapsed <= teElapsed + 6'h01;
      end else begin
        teDiv <= teDiv + 12'h001;
      end
    end
  end

  // Pin drive: line belongs to the programmer's data while in programming mode
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pwmOut <= 1'b0;
      pwmOe  <= 1'b1;
    end else if (progSync) begin
      pwmOut <= progTxData;
      pwmOe  <= progTxEn;
    end else begin
      pwmOut <= pwmLine;
      pwmOe  <= 1'b1;
    end
  end
endmodule

/* rtl/placeholder_none.v */
`timescale 1ns/10ps

/* verification/hce_core_asserts.sv */
`timescale 1ns/10ps
module hce_core_asserts (
  // Clock and reset
  input wire        clk_sys,
  input wire        arst_n,
  // Pins
  input wire        buttonInZero,
  input wire        buttonInOne,
  input wire        buttonInTwoProgClock,
  input wire        progMode,
  input wire        progTxEn,
  input wire        pwmOut,
  input wire        pwmOe,
  input wire        progClkRise,
  // Status
  input wire        awake,
  input wire [15:0] syncValue,
  input wire        syncWrite
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire held = buttonInZero | buttonInOne | buttonInTwoProgClock;

  property p_sync_step;
    (syncValue != $past(syncValue)) |-> (syncValue == $past(syncValue) + 16'h1);
  endproperty
  a_sync_step: assert property (p_sync_step)
    else $error("sync counter moved by other than one");
  property p_sync_pulse;
    syncWrite |=> !syncWrite;
  endproperty
  a_sync_pulse: assert property (p_sync_pulse)
    else $error("sync write longer than one cycle");
  property p_wake;
    held && !awake && !progMode |-> ##[1:6] awake;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake on button closure");
  property p_debounce;
    $rose(awake) |-> !syncWrite [*8];
  endproperty
  a_debounce: assert property (p_debounce)
    else $error("counter advanced inside debounce");
  property p_idle_pin;
    (!awake && !progMode) [*5] |-> !pwmOut;
  endproperty
  a_idle_pin: assert property (p_idle_pin)
    else $error("pin high while asleep");
  property p_prog_pulse;
    progClkRise |=> !progClkRise;
  endproperty
  a_prog_pulse: assert property (p_prog_pulse)
    else $error("clock pulse longer than one cycle");
  property p_prog_only;
    (!progMode) [*5] |-> !progClkRise;
  endproperty
  a_prog_only: assert property (p_prog_only)
    else $error("clock pulse outside programming mode");
  property p_oe_normal;
    (!progMode) [*5] |-> pwmOe;
  endproperty
  a_oe_normal: assert property (p_oe_normal)
    else $error("pin not driven in normal mode");
  property p_oe_prog;
    (progMode && $stable(progTxEn)) [*4] |-> (pwmOe == progTxEn);
  endproperty
  a_oe_prog: assert property (p_oe_prog)
    else $error("pin enable does not follow request");
endmodule

bind hce_core hce_core_asserts u_asserts (
  .clk_sys(clk_sys), .arst_n(arst_n), .buttonInZero(buttonInZero),
  .buttonInOne(buttonInOne), .buttonInTwoProgClock(buttonInTwoProgClock),
  .progMode(progMode), .progTxEn(progTxEn), .pwmOut(pwmOut), .pwmOe(pwmOe),
  .progClkRise(progClkRise), .awake(awake), .syncValue(syncValue), .syncWrite(syncWrite)
);

/* verification/hce_rx_model.sv */
`timescale 1ns/10ps
module hce_rx_model (
  // Clock and reset
  input  wire         clk_sys,
  input  wire         arst_n,
  // Pin
  input  wire         pwmOut,
  input  wire         pwmOe,
  input  wire         txBit,
  output wire         pwmIn,
  // Measured pulse widths and rising-edge count
  output logic [15:0] lastHigh,
  output logic [15:0] lastLow,
  output logic [15:0] riseCount
);
  logic [15:0] run;
  logic        prev;
  // Programmer drives only while the device has let go
  assign pwmIn = pwmOe ? pwmOut : txBit;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      run <= 16'h0;
      prev <= 1'b0;
      lastHigh <= 16'h0;
      lastLow <= 16'h0;
      riseCount <= 16'h0;
    end else begin
      prev <= pwmIn;
      if (pwmIn != prev) begin
        run <= 16'h1;
        if (prev) begin
          lastHigh <= run;
        end else begin
          lastLow <= run;
          riseCount <= riseCount + 16'h1;
        end
      end else begin
        run <= run + 16'h1;
      end
    end
  end
endmodule

/* verification/hopping_code_encoder_core_test.sv */
`timescale 1ns/10ps
module hopping_code_encoder_core_test;
  localparam int DEB = 20;
  localparam int RND = 64;
  localparam int TE  = 4000;
  logic        clk_sys, arst_n, lowSupplyFlag, progMode, seedEnable;
  logic        progTxData, progTxEn, txBit;
  logic [2:0]  btn, c;
  logic [63:0] cipherKey;
  logic [31:0] serialNumber;
  logic [47:0] seedValue;
  logic [9:0]  discBits;
  logic [15:0] expSync;
  wire         pwmIn, pwmOut, pwmOe, progClkRise, progDataIn, awake, syncWrite;
  wire  [15:0] syncValue, lastHigh, lastLow, riseCount;
  int          fails, comparisons, k, r;

  hce_core #(.DEBOUNCE_CYCLES(DEB), .ROUNDS(RND)) u_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .buttonInZero(btn[0]), .buttonInOne(btn[1]),
    .buttonInTwoProgClock(btn[2]), .lowSupplyFlag(lowSupplyFlag), .progMode(progMode),
    .cipherKey(cipherKey), .serialNumber(serialNumber), .seedValue(seedValue),
    .seedEnable(seedEnable), .discBits(discBits), .pwmIn(pwmIn), .pwmOut(pwmOut),
    .pwmOe(pwmOe), .progTxData(progTxData), .progTxEn(progTxEn),
    .progClkRise(progClkRise), .progDataIn(progDataIn), .awake(awake),
    .syncValue(syncValue), .syncWrite(syncWrite)
  );
  hce_rx_model u_rx (
    .clk_sys(clk_sys), .arst_n(arst_n), .pwmOut(pwmOut), .pwmOe(pwmOe), .txBit(txBit),
    .pwmIn(pwmIn), .lastHigh(lastHigh), .lastLow(lastLow), .riseCount(riseCount)
  );

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic close_out();
    $display("Counts: %0d mismatches, %0d comparisons", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  function automatic logic sig(input int w);
    case (w)
      0: sig = syncWrite === 1'b1;
      1: sig = pwmOut === 1'b1;
      2: sig = pwmOut === 1'b0;
      3: sig = awake === 1'b0;
      default: sig = progClkRise === 1'b1;
    endcase
  endfunction
  // Bounded so a stuck design still reaches the verdict
  task automatic wait_for(input int w, input int lim, output int n);
    n = 0;
    while (n < lim && !sig(w)) begin
      @(negedge clk_sys);
      n++;
    end
    if (!sig(w)) begin
      fails++;
      $display("[FAIL] %0t wait ran out", $time);
      close_out();
    end
  endtask
  // Sync counter has no stored load, so reset clears it
  task automatic reset_dut();
    btn = 3'h0;
    arst_n = 1'b0;
    tick(2);
    arst_n = 1'b1;
    expSync = 16'h0;
  endtask

  initial begin
    fails = 0;
    comparisons = 0;
    r = $urandom(32'h7270de80);
    arst_n = 1'b0;
    btn = 3'h0;
    {progMode, progTxData, progTxEn, txBit} = 4'h0;
    lowSupplyFlag = 1'($urandom);
    seedEnable = 1'($urandom);
    cipherKey = {$urandom, $urandom};
    serialNumber = $urandom;
    seedValue = 48'({$urandom, $urandom});
    discBits = 10'($urandom);
    expSync = 16'h0;
    tick(5);
    arst_n = 1'b1;
    check(16'({pwmOe, pwmOut}), 16'h2);
    check(16'(awake | syncWrite), 16'h0);
    check(syncValue, 16'h0);
    // Release inside debounce
    btn = 3'h2;
    tick(DEB / 2 + $urandom % 4);
    btn = 3'h0;
    tick(DEB + 10);
    check(syncValue, expSync);
    // Every combination, each but all three buttons aborted by more buttons
    r = $urandom % 7;
    for (int i = 0; i < 7; i++) begin
      c = 3'((i + r) % 7 + 1);
      btn = c;
      wait_for(0, DEB + 20, k);
      expSync++;
      check(16'(k >= DEB && k <= DEB + 6), 16'h1);
      tick(1);
      check(syncValue, expSync);
      if (c != 3'h7) begin
        btn = 3'h7;
        wait_for(3, 10, k);
        wait_for(0, DEB + 20, k);
        expSync++;
        tick(1);
        check(syncValue, expSync);
      end
      reset_dut();
    end
    // Preamble, release, then abort in mid-frame
    c = 3'($urandom % 6 + 1);
    btn = c;
    wait_for(0, DEB + 20, k);
    wait_for(1, RND + 50, k);
    wait_for(2, TE + 100, k);
    tick(1);
    check(lastHigh, 16'(TE));
    wait_for(1, TE + 100, k);
    tick(1);
    check(lastLow, 16'(TE));
    btn = 3'h0;
    wait_for(2, TE + 100, k);
    wait_for(1, TE + 100, k);
    check(lastHigh, 16'(TE));
    check(riseCount, 16'h2);
    check(16'(awake), 16'h1);
    btn = ~c;
    wait_for(3, 10, k);
    tick(1);
    check(16'(pwmOut), 16'h0);
    btn = 3'h0;
    tick(DEB + 10);
    check(syncValue, 16'h1);
    // Programming mode: third button is a clock
    progMode = 1'b1;
    tick(4);
    for (int i = 0; i < 4; i++) begin
      txBit = 1'($urandom);
      btn = 3'h4;
      wait_for(4, 8, k);
      check(16'(progDataIn), 16'(txBit));
      btn = 3'h0;
      tick(4);
    end
    check(16'(awake), 16'h0);
    check(syncValue, 16'h1);
    progTxData = 1'($urandom);
    progTxEn = 1'b1;
    tick(4);
    check(16'({pwmOe, pwmOut}), 16'({1'b1, progTxData}));
    progTxEn = 1'b0;
    tick(4);
    check(16'(pwmOe), 16'h0);
    progMode = 1'b0;
    tick(6);
    close_out();
  end
endmodule
